// file: common/smsw_map.svh
`ifndef SMSW_MAP_SVH
`define SMSW_MAP_SVH
// Function
// - sleep command takes effect only at the chip-select rising edge ending the frame.
// - entering sleep releases the active-low supply enable to high.
// - waking drives supply enable low; a falling edge on the shared line wakes this device.
// - switch change during a sleep frame keeps the device in normal mode.
// - a switch status command wakes a sleeping device; first data may be unsettled.
// - internal power-on reset returns to normal mode with default registers.
// - supply enable low throughout normal mode, high throughout sleep mode.
// - in sleep, closure on a wake-enabled input wakes and pulls enable low.
// - wake cause is recorded in a readable flag for the host.
// - chip-select falling edge during sleep returns device to normal mode.
// - power-up starts in normal mode with all switch inputs tri-stated.

// ----------------------------------------------------------------------
// frame and command layout
// ----------------------------------------------------------------------
`define SMSW_WORD_W      24
`define SMSW_CMD_MSB     23
`define SMSW_CMD_LSB     16
`define SMSW_CMD_SLEEP   8'h01
`define SMSW_CMD_STATUS  8'h00
`define SMSW_NUM_SW      22
`define SMSW_CAUSE_W     3
`define SMSW_CAUSE_NONE  3'h0
`define SMSW_CAUSE_SW    3'h1
`define SMSW_CAUSE_CS    3'h2
`define SMSW_CAUSE_LINE  3'h4
`endif

// file: common/smsw_pkg.sv
`include "smsw_map.svh"
package smsw_pkg;
  typedef enum logic [1:0] {
    SMSW_NORMAL = 2'b01,
    SMSW_SLEEP  = 2'b10
  } smsw_mode_e;

  // synchronised serial pins travel together
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } smsw_spi_s;

  typedef logic [`SMSW_WORD_W-1:0] smsw_word_t;
endpackage : smsw_pkg

// file: design/smsw_sync.sv
// two-flop synchroniser bank for pins from outside the clock domain
module smsw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          // both stages start at the idle level so no false edge follows reset
          meta_r[g] <= rst_val_i[g];
          q_o[g]    <= rst_val_i[g];
        end else begin
          meta_r[g] <= d_i[g];
          q_o[g]    <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule : smsw_sync

// file: design/smsw_ctrl.sv
`include "smsw_map.svh"
// sleep and wake controller with serial shift path
module smsw_ctrl
  import smsw_pkg::*;
(
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     cs_n_i,
  input  wire logic                     sclk_i,
  input  wire logic                     mosi_i,
  output logic                          miso_o,
  input  wire logic [`SMSW_NUM_SW-1:0]  switch_i,
  input  wire logic [`SMSW_NUM_SW-1:0]  wake_en_i,
  input  wire logic                     wake_n_i,
  output logic                          wake_n_o,
  output logic                          wake_n_oe_o,
  output logic                          sleep_o,
  output logic                          tristate_all_o,
  output logic [`SMSW_CAUSE_W-1:0]      wake_cause_o,
  output logic                          cmd_valid_o,
  output logic [`SMSW_WORD_W-1:0]       cmd_word_o
);
  localparam int NS = `SMSW_NUM_SW + 3; // switches plus chip select, clock and wake line

  smsw_spi_s                 spi_s;
  logic [NS-1:0]             sync_q;
  logic [`SMSW_NUM_SW-1:0]   sw_q;
  logic                      wake_line_q;
  logic                      cs_d_r;
  logic                      sclk_d_r;
  logic [`SMSW_NUM_SW-1:0]   sw_d_r;
  smsw_mode_e                mode_r;
  smsw_word_t                shift_r;
  logic                      sw_chg_r;
  logic                      wake_d_r;
  logic                      frame_awake_r;
  logic                      cs_rise;
  logic                      cs_fall;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      sw_change;
  logic                      sw_wake;
  logic                      line_fall;
  logic [7:0]                cmd_code;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  smsw_sync #(.W(NS)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       ({cs_n_i, sclk_i, wake_n_i, switch_i}),
    .rst_val_i ({1'b1, 1'b0, 1'b1, {`SMSW_NUM_SW{1'b0}}}), // pin idle levels
    .q_o       (sync_q)
  );
  // mosi has a pair of its own; it is only read on a synchronised clock edge
  logic mosi_m_r;
  logic mosi_q_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mosi_m_r <= 1'b0;
      mosi_q_r <= 1'b0;
    end else begin
      mosi_m_r <= mosi_i;
      mosi_q_r <= mosi_m_r;
    end
  end

  assign spi_s.cs_n  = sync_q[NS-1];
  assign spi_s.sclk  = sync_q[NS-2];
  assign spi_s.mosi  = mosi_q_r;
  assign wake_line_q = sync_q[`SMSW_NUM_SW];
  assign sw_q        = sync_q[`SMSW_NUM_SW-1:0];

  // decodes the command byte of a frame word
  function automatic logic [7:0] cmd_of(input smsw_word_t w);
    cmd_of = w[`SMSW_CMD_MSB:`SMSW_CMD_LSB];
  endfunction : cmd_of

  // ----------------------------------------------------------------------
  // edge detection on synchronised levels
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
      sw_d_r   <= '0;
      wake_d_r <= 1'b1;
    end else begin
      cs_d_r   <= spi_s.cs_n;
      sclk_d_r <= spi_s.sclk;
      sw_d_r   <= sw_q;
      wake_d_r <= wake_line_q;
    end
  end

  assign cs_rise   = spi_s.cs_n & ~cs_d_r;
  assign cs_fall   = ~spi_s.cs_n & cs_d_r;
  assign sclk_rise = spi_s.sclk & ~sclk_d_r & ~spi_s.cs_n;
  assign sclk_fall = ~spi_s.sclk & sclk_d_r & ~spi_s.cs_n;
  assign sw_change = |(sw_q ^ sw_d_r);
  // our own release lets the line rise; only a later fall means another device woke
  assign line_fall = ~wake_line_q & wake_d_r;
  // any level change counts, closing or opening; only wake-enabled inputs count
  assign sw_wake   = |((sw_q ^ sw_d_r) & wake_en_i);
  assign cmd_code  = cmd_of(shift_r);

  // ----------------------------------------------------------------------
  // shift register; any frame length works, 48 clocks load a pair
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      shift_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[`SMSW_WORD_W-2:0], spi_s.mosi};
    end
  end

  // output bit changes on falling sclk so the next device samples it stable
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      miso_o <= 1'b0;
    end else if (sclk_fall) begin
      miso_o <= shift_r[`SMSW_WORD_W-1];
    end else if (cs_fall) begin
      miso_o <= shift_r[`SMSW_WORD_W-1];
    end
  end

  // ----------------------------------------------------------------------
  // switch change seen during a frame vetoes sleep entry
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sw_chg_r <= 1'b0;
    end else if (!spi_s.cs_n && sw_change) begin
      sw_chg_r <= 1'b1;
    end else if (cs_fall) begin
      sw_chg_r <= 1'b0; // a change in the opening cycle still wins
    end
  end

  // ----------------------------------------------------------------------
  // mode machine; power-on reset lands in normal
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_r <= SMSW_NORMAL;
    end else begin
      case (mode_r)
        SMSW_NORMAL: begin
          // decode only the word standing at the closing edge
          if (cs_rise && cmd_code == `SMSW_CMD_SLEEP && !sw_chg_r && !sw_change) begin
            mode_r <= SMSW_SLEEP;
          end
        end
        SMSW_SLEEP: begin
          // status access also begins with a falling chip select
          if (sw_wake || cs_fall || line_fall) begin
            mode_r <= SMSW_NORMAL;
          end
        end
        default: mode_r <= SMSW_NORMAL;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // supply enable: low in normal, released in sleep
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wake_n_o    <= 1'b0;
      wake_n_oe_o <= 1'b1;
      sleep_o     <= 1'b0;
    end else begin
      wake_n_o    <= 1'b0;
      wake_n_oe_o <= (mode_r == SMSW_NORMAL);
      sleep_o     <= (mode_r == SMSW_SLEEP);
    end
  end

  // ----------------------------------------------------------------------
  // wake cause flag, cleared when a status frame opened in normal mode closes
  // ----------------------------------------------------------------------
  // the waking frame must not clear the cause, or the host could never read it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      frame_awake_r <= 1'b0;
    end else if (cs_fall) begin
      frame_awake_r <= (mode_r == SMSW_NORMAL);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wake_cause_o <= `SMSW_CAUSE_NONE;
    end else if (mode_r == SMSW_SLEEP) begin
      if (sw_wake) begin
        wake_cause_o <= `SMSW_CAUSE_SW;
      end else if (cs_fall) begin
        wake_cause_o <= `SMSW_CAUSE_CS;
      end else if (line_fall) begin
        wake_cause_o <= `SMSW_CAUSE_LINE;
      end
    end else if (cs_rise && frame_awake_r && cmd_code == `SMSW_CMD_STATUS) begin
      wake_cause_o <= `SMSW_CAUSE_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // decoded word handed on; inputs tri-stated until first command
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_valid_o    <= 1'b0;
      cmd_word_o     <= '0;
      tristate_all_o <= 1'b1;
    end else begin
      cmd_valid_o <= cs_rise;
      if (cs_rise) begin
        cmd_word_o     <= shift_r;
        tristate_all_o <= 1'b0;
      end
    end
  end
endmodule : smsw_ctrl

// file: test/smsw_ctrl_sva.sv
`include "smsw_map.svh"
// mode, wake drive and decode relations seen at the controller ports
module smsw_ctrl_sva (
  input wire logic                     clk_sys_i,
  input wire logic                     rst_i,
  input wire logic                     cs_n_i,
  input wire logic [`SMSW_NUM_SW-1:0]  switch_i,
  input wire logic [`SMSW_NUM_SW-1:0]  wake_en_i,
  input wire logic                     wake_n_i,
  input wire logic                     wake_n_oe_o,
  input wire logic                     sleep_o,
  input wire logic                     tristate_all_o,
  input wire logic [`SMSW_CAUSE_W-1:0] wake_cause_o,
  input wire logic                     cmd_valid_o,
  input wire logic [`SMSW_WORD_W-1:0]  cmd_word_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_OE_MODE: assert property (wake_n_oe_o == !sleep_o)
    else $error("wake drive differs from mode");
  AST_SLEEP_CMD: assert property ($rose(sleep_o) |-> $past(cmd_valid_o)
    && cmd_word_o[`SMSW_CMD_MSB:`SMSW_CMD_LSB] == `SMSW_CMD_SLEEP) else $error("bad sleep");
  AST_RELEASE: assert property ($rose(sleep_o) |-> !wake_n_oe_o)
    else $error("wake line held on sleep");
  AST_CS_WAKE: assert property (sleep_o && $fell(cs_n_i) |-> ##[1:8] !sleep_o)
    else $error("no wake on select");
  AST_LINE_WAKE: assert property (sleep_o && $fell(wake_n_i) |-> ##[1:8] !sleep_o)
    else $error("no wake on line");
  AST_SW_WAKE: assert property (sleep_o && |(wake_en_i & (switch_i ^ $past(switch_i)))
    |-> ##[1:8] !sleep_o) else $error("no wake on switch");
  AST_POR: assert property (disable iff (1'b0) rst_i |=> !sleep_o && wake_n_oe_o
    && tristate_all_o && wake_cause_o == `SMSW_CAUSE_NONE) else $error("bad reset state");
  AST_CAUSE: assert property ($fell(sleep_o) |-> ##[0:2] wake_cause_o != 3'h0)
    else $error("no wake cause");
endmodule : smsw_ctrl_sva

bind smsw_ctrl smsw_ctrl_sva smsw_ctrl_sva_inst (.clk_sys_i, .rst_i, .cs_n_i, .switch_i,
  .wake_en_i, .wake_n_i, .wake_n_oe_o, .sleep_o, .tristate_all_o, .wake_cause_o,
  .cmd_valid_o, .cmd_word_o);

// file: test/smsw_host_model.sv
// host on the serial port; clock stands low between frames
module smsw_host_model (
  input  wire logic miso_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [47:0] rx;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // msb first at 80 ns; data inverted once released so no stale bit looks valid
  task automatic frame(input logic [47:0] w, input int n);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = w[i];
      #40 sclk_o = 1'b1;
      rx = {rx[46:0], miso_i};
      #40 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : frame
endmodule : smsw_host_model

// file: test/test_smsw_ctrl.sv
`include "smsw_map.svh"
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module test_smsw_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import smsw_pkg::*;
  localparam smsw_word_t SLP = {`SMSW_CMD_SLEEP, 16'h0000};
  localparam smsw_word_t STA = {`SMSW_CMD_STATUS, 16'hA5C3};
  // stands in for the host's 10 to 20 ms settle gap, cut short to keep the run brief
  localparam int         SETTLE = 200;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic                     ext_low = 1'b0;
  logic [`SMSW_NUM_SW-1:0]  sw = '0;
  logic [`SMSW_NUM_SW-1:0]  en = 22'h3FFFFD;
  logic                     cs_n, sclk, mosi, miso, wn_o, oe, slp, tris, cv;
  logic [`SMSW_CAUSE_W-1:0] cause;
  smsw_word_t               cw;
  int                       n_mismatch = 0;
  int                       n_compared = 0;
  int                       cyc = 0;
  // shared wake line, pulled up when nobody drives it
  wire wline = ext_low ? 1'b0 : (oe ? wn_o : 1'b1);
  always #5 clk_sys_i = ~clk_sys_i;
  smsw_ctrl smsw_ctrl_inst (.clk_sys_i, .rst_i, .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
    .miso_o(miso), .switch_i(sw), .wake_en_i(en), .wake_n_i(wline), .wake_n_o(wn_o),
    .wake_n_oe_o(oe), .sleep_o(slp), .tristate_all_o(tris), .wake_cause_o(cause),
    .cmd_valid_o(cv), .cmd_word_o(cw));
  smsw_host_model smsw_host_model_inst (.miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk),
    .mosi_o(mosi));
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // cut a hang short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc_n
  // one frame, then wait for the decode pulse and one more cycle for the mode
  task automatic send(input logic [47:0] w, input int n);
    int k;
    k = 0;
    smsw_host_model_inst.frame(w, n);
    while (cv !== 1'b1 && k < 20) begin
      cyc_n(1);
      k++;
    end
    `CHK("valid", 1'b1, cv)
    cyc_n(1);
  endtask : send
  task automatic go_sleep();
    send(STA, 24);
    send(SLP, 24);
    `CHK("sleep", 1'b1, slp)
    `CHK("drive", 1'b0, oe)
  endtask : go_sleep
  task automatic wake_wait();
    int k;
    k = 0;
    while (slp !== 1'b0 && k < 20) begin
      cyc_n(1);
      k++;
    end
  endtask : wake_wait
  task automatic t_reset();
    `CHK("tristate", 1'b1, tris)
    `CHK("sleep", 1'b0, slp)
    `CHK("drive", 1'b1, oe)
    `CHK("cause", `SMSW_CAUSE_NONE, cause)
  endtask : t_reset
  task automatic t_cs_wake();
    go_sleep();
    send(STA, 24);
    `CHK("sleep", 1'b0, slp)
    `CHK("cause", `SMSW_CAUSE_CS, cause)
    cyc_n(SETTLE);
    send(STA, 24);
    `CHK("cause", `SMSW_CAUSE_NONE, cause)
  endtask : t_cs_wake
  task automatic t_sw_wake();
    go_sleep();
    sw[1] = ~sw[1];
    cyc_n(10);
    `CHK("sleep", 1'b1, slp)
    sw[0] = ~sw[0];
    wake_wait();
    `CHK("sleep", 1'b0, slp)
    `CHK("cause", `SMSW_CAUSE_SW, cause)
    send(STA, 24);
  endtask : t_sw_wake
  task automatic t_line_wake();
    go_sleep();
    // let the released line rise and be seen before another device pulls it
    cyc_n(5);
    `CHK("sleep", 1'b1, slp)
    ext_low = 1'b1;
    wake_wait();
    `CHK("drive", 1'b1, oe)
    `CHK("cause", `SMSW_CAUSE_LINE, cause)
    ext_low = 1'b0;
    send(STA, 24);
  endtask : t_line_wake
  // switch moves mid-frame, so the sleep request must be dropped
  task automatic t_refuse();
    fork
      send(SLP, 24);
      begin
        cyc_n(60);
        sw[3] = ~sw[3];
      end
    join
    `CHK("sleep", 1'b0, slp)
  endtask : t_refuse
  task automatic t_chain();
    send({STA, SLP}, 48);
    `CHK("word", SLP, cw)
    `CHK("shift", STA, smsw_host_model_inst.rx[23:0])
    `CHK("passed", SLP, smsw_host_model_inst.rx[47:24])
    `CHK("sleep", 1'b1, slp)
    send(STA, 24);
  endtask : t_chain
  task automatic t_por();
    go_sleep();
    rst_i = 1'b1;
    cyc_n(2);
    rst_i = 1'b0;
    cyc_n(3);
    `CHK("sleep", 1'b0, slp)
    `CHK("drive", 1'b1, oe)
    send(STA, 24);
    `CHK("tristate", 1'b0, tris)
  endtask : t_por
  initial begin
    repeat (16) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    cyc_n(3);
    t_reset();
    t_cs_wake();
    t_sw_wake();
    t_line_wake();
    t_refuse();
    t_chain();
    t_por();
    stop_test();
  end
endmodule : test_smsw_ctrl
